/* File: hw/cangs_top.sv */
// CAN global status and general interrupt flag registers
//
// Summary of operation
// - Overload bit high while sending own overload
// - Transmitter busy during frames or pending IFS
// - Enabled bit shows mode actually in force
// - Enabled bit lags run command four clocks when starting
// - Bit 7 is OR of all requests
// - Timer wrap flag on FFFF to 0000
// - Timer wrap requests only when enabled
// - Overrun flag bit4 set on full buffer
// - Form error latched on fixed field violation
// - Reserved bits read zero, write zero
// - Status register resets to zero
// - Interrupt flag register resets to zero
`default_nettype none
module cangs_top (
    input  wire logic        clk,            // Controller clock, 20 MHz
    input  wire logic        rst,            // Synchronous reset, active high
    input  wire logic [7:0]  sfrAddr,        // SFR address
    input  wire logic        sfrWr,          // SFR write strobe
    input  wire logic        sfrRd,          // SFR read strobe
    input  wire logic [7:0]  sfrWdata,       // SFR write data
    output logic      [7:0]  sfrRdata,       // SFR read data, registered
    input  wire logic        controllerRunEnable, // Requested run mode
    input  wire logic        ovlSending,     // Own overload frame on bus
    input  wire logic        txFrame,        // Transmitter drives a frame or ack
    input  wire logic        txPending,      // Frame waiting during IFS
    input  wire logic        inIfs,          // Interframe spacing in progress
    input  wire logic        rxFrame,        // Receiver acquiring or monitoring
    input  wire logic [1:0]  faultState,     // 0 active, 1 passive, 2/3 bus-off
    input  wire logic [15:0] canTimer,       // Free running CAN timer value
    input  wire logic        timerWrapIrqEnable, // Timer wrap enable, extended enable register
    input  wire logic        bufferFull,     // Reception buffer became full
    input  wire logic        stuffErr,       // Six equal bits seen
    input  wire logic        crcErr,         // CRC mismatch
    input  wire logic        formErr,        // Fixed form field violated
    input  wire logic        ackErr,         // Recessive ack slot
    input  wire logic        otherIrq,       // Other controller interrupt requests
    input  wire logic        errIrqEnable,   // General error interrupt enable
    input  wire logic        bufIrqEnable,   // Buffer interrupt enable
    output logic      [7:0]  canGlobalStatus,          // Status image
    output logic      [7:0]  canGlobalInterruptFlags,  // Flag image
    output logic             anyIrqPending   // Request to interrupt controller
);
    logic [15:0] tmrPrev_r;          // Timer value of previous cycle
    logic        tmrValid_r;         // Previous timer value is meaningful
    logic [1:0]  startCnt_r;         // Start delay counter
    cangs_pkg::cangs_en_t enState_r; // Enable sequencer state
    logic        enabled;            // Mode in force
    logic [5:0]  setEvt;             // Flag set events
    logic [5:0]  flags;              // Latched flags
    logic        gitWr;              // Write to flag register
    logic        irqAny;             // Combined request
    logic        twrapEvt;           // Timer rollover seen
    logic        busOff;             // Bus-off decode
    logic        errPassive;         // Error passive decode

    // Decode a confinement code into its state
    function automatic cangs_pkg::cangs_fc_t fcDecode(input logic [1:0] code);
        if (code[1]) begin
            return cangs_pkg::CANGS_FC_BUSOFF;
        end else if (code[0]) begin
            return cangs_pkg::CANGS_FC_PASSIVE;
        end else begin
            return cangs_pkg::CANGS_FC_ACTIVE;
        end
    endfunction

    assign busOff     = (fcDecode(faultState) == cangs_pkg::CANGS_FC_BUSOFF);
    assign errPassive = (fcDecode(faultState) == cangs_pkg::CANGS_FC_PASSIVE);

    // Enable sequencer: run command reaches the status after four clocks
    always_ff @(posedge clk) begin
        if (rst) begin
            enState_r  <= cangs_pkg::CANGS_EN_OFF;
            startCnt_r <= 2'h0;
        end else begin
            unique case (enState_r)
                cangs_pkg::CANGS_EN_OFF: begin
                    if (controllerRunEnable) begin
                        enState_r  <= cangs_pkg::CANGS_EN_START;
                        startCnt_r <= 2'h1;
                    end
                end
                cangs_pkg::CANGS_EN_START: begin
                    // Abort if the request is dropped
                    if (!controllerRunEnable) begin
                        enState_r <= cangs_pkg::CANGS_EN_OFF;
                    end else if (startCnt_r == cangs_pkg::CANGS_START_CYC) begin
                        enState_r <= cangs_pkg::CANGS_EN_ON;
                    end else begin
                        startCnt_r <= startCnt_r + 2'h1;
                    end
                end
                cangs_pkg::CANGS_EN_ON: begin
                    // Standby only once ongoing frame work has ended
                    if (!controllerRunEnable && !txFrame && !rxFrame) begin
                        enState_r <= cangs_pkg::CANGS_EN_OFF;
                    end
                end
                default: begin
                    enState_r <= cangs_pkg::CANGS_EN_OFF;
                end
            endcase
        end
    end

    assign enabled = (enState_r == cangs_pkg::CANGS_EN_ON);

    // Timer history for rollover detection
    always_ff @(posedge clk) begin
        if (rst) begin
            tmrPrev_r  <= 16'h0000;
            tmrValid_r <= 1'b0;
        end else begin
            tmrPrev_r  <= canTimer;
            tmrValid_r <= 1'b1;
        end
    end

    assign twrapEvt = tmrValid_r && (tmrPrev_r == cangs_pkg::CANGS_TMR_MAX)
                      && (canTimer == cangs_pkg::CANGS_TMR_ZERO);

    // Event vector in flag order: wrap, overrun, stuff, crc, form, ack
    assign setEvt = {twrapEvt, bufferFull, stuffErr, crcErr, formErr, ackErr};
    assign gitWr  = sfrWr && (sfrAddr == cangs_pkg::CANGS_GIT_ADDR);

    cangs_err_latch uFlags (
        .clk     (clk),
        .rst     (rst),
        .setEvt  (setEvt),
        .clrWr   (gitWr),
        .clrData (sfrWdata[5:0]),
        .flags   (flags)
    );

    // Combine gated requests with the other controller sources
    assign irqAny = (flags[5] && timerWrapIrqEnable)
                    || (flags[4] && bufIrqEnable)
                    || ((|flags[3:0]) && errIrqEnable)
                    || otherIrq;

    // Status register image, no interrupt from any status bit
    always_ff @(posedge clk) begin
        if (rst) begin
            canGlobalStatus <= cangs_pkg::CANGS_GSTA_RESET;
        end else begin
            canGlobalStatus[7] <= cangs_pkg::CANGS_RSVD_VAL;
            canGlobalStatus[5] <= cangs_pkg::CANGS_RSVD_VAL;
            canGlobalStatus[cangs_pkg::CANGS_STA_OVL_BIT] <= ovlSending;
            canGlobalStatus[cangs_pkg::CANGS_STA_TXACT_BIT] <= txFrame
                                                             || (inIfs && txPending);
            canGlobalStatus[cangs_pkg::CANGS_STA_RXACT_BIT] <= rxFrame;
            canGlobalStatus[cangs_pkg::CANGS_STA_RUN_BIT] <= enabled;
            canGlobalStatus[cangs_pkg::CANGS_STA_BUSOFF_BIT] <= busOff;
            canGlobalStatus[cangs_pkg::CANGS_STA_PASSIVE_BIT] <= errPassive;
        end
    end

    // Flag register image and interrupt output
    always_ff @(posedge clk) begin
        if (rst) begin
            canGlobalInterruptFlags <= cangs_pkg::CANGS_GIT_RESET;
            anyIrqPending           <= 1'b0;
        end else begin
            canGlobalInterruptFlags <= {irqAny, cangs_pkg::CANGS_RSVD_VAL, flags};
            anyIrqPending           <= irqAny;
        end
    end

    // Read data path; unmapped addresses return zero
    always_ff @(posedge clk) begin
        if (rst) begin
            sfrRdata <= 8'h00;
        end else if (sfrRd) begin
            unique case (sfrAddr)
                cangs_pkg::CANGS_GIT_ADDR:  sfrRdata <= canGlobalInterruptFlags;
                cangs_pkg::CANGS_GSTA_ADDR: sfrRdata <= canGlobalStatus;
                default:                    sfrRdata <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: hw/cangs_pkg.sv */
// Package: register map, field positions, reset values and timing of the CAN global status block
`default_nettype none
package cangs_pkg;
    // Register offsets in the special-function-register space
    localparam logic [7:0] CANGS_GIT_ADDR  = 8'h9B;
    localparam logic [7:0] CANGS_GSTA_ADDR = 8'hAA;
    // Status register field positions
    localparam int CANGS_STA_OVL_BIT     = 6;
    localparam int CANGS_STA_TXACT_BIT   = 4;
    localparam int CANGS_STA_RXACT_BIT   = 3;
    localparam int CANGS_STA_RUN_BIT     = 2;
    localparam int CANGS_STA_BUSOFF_BIT  = 1;
    localparam int CANGS_STA_PASSIVE_BIT = 0;
    // Interrupt flag register field positions
    localparam int CANGS_GIT_ANY_BIT   = 7;
    localparam int CANGS_GIT_TWRAP_BIT = 5;
    localparam int CANGS_GIT_OVRB_BIT  = 4;
    localparam int CANGS_GIT_STUFF_BIT = 3;
    localparam int CANGS_GIT_CRC_BIT   = 2;
    localparam int CANGS_GIT_FORM_BIT  = 1;
    localparam int CANGS_GIT_ACK_BIT   = 0;
    // Reset values
    localparam logic [7:0] CANGS_GSTA_RESET = 8'h00;
    localparam logic [7:0] CANGS_GIT_RESET  = 8'h00;
    // Value returned for reserved bits
    localparam logic       CANGS_RSVD_VAL   = 1'b0;
    // Controller clock periods needed before the protocol machine runs
    localparam logic [1:0] CANGS_START_CYC  = 2'h2;
    // CAN timer limits
    localparam logic [15:0] CANGS_TMR_MAX   = 16'hFFFF;
    localparam logic [15:0] CANGS_TMR_ZERO  = 16'h0000;
    // Fault confinement states
    typedef enum logic [2:0] {
        CANGS_FC_ACTIVE  = 3'b001,
        CANGS_FC_PASSIVE = 3'b010,
        CANGS_FC_BUSOFF  = 3'b100
    } cangs_fc_t;
    // Enable sequencer states
    typedef enum logic [2:0] {
        CANGS_EN_OFF   = 3'b001,
        CANGS_EN_START = 3'b010,
        CANGS_EN_ON    = 3'b100
    } cangs_en_t;
endpackage
`default_nettype wire

/* File: hw/cangs_err_latch.sv */
// Sticky error and event flag bank with software write-zero clear
`default_nettype none
module cangs_err_latch (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [5:0] setEvt,
    input  wire logic       clrWr,
    input  wire logic [5:0] clrData,
    output logic      [5:0] flags
);
    // Set wins over a same-cycle clear; writing zero clears, one keeps
    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= '0;
        end else if (clrWr) begin
            flags <= (flags & clrData) | setEvt;
        end else begin
            flags <= flags | setEvt;
        end
    end
endmodule
`default_nettype wire

/* File: test/cangs_monitor.sv */
// Port checker for the CAN global status block
`default_nettype none
module cangs_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  sfrAddr,
    input wire logic        sfrWr,
    input wire logic [7:0]  sfrWdata,
    input wire logic        controllerRunEnable,
    input wire logic        ovlSending,
    input wire logic        txFrame,
    input wire logic        txPending,
    input wire logic        inIfs,
    input wire logic        rxFrame,
    input wire logic [1:0]  faultState,
    input wire logic [15:0] canTimer,
    input wire logic        stuffErr,
    input wire logic        formErr,
    input wire logic [7:0]  canGlobalStatus,
    input wire logic [7:0]  canGlobalInterruptFlags,
    input wire logic        anyIrqPending
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Not the first edge after reset
    sequence s_live;
        !$past(rst);
    endsequence
    // Enable bit still off on four consecutive edges
    sequence s_wait;
        !canGlobalStatus[2] [*4];
    endsequence
    // Event seen two edges later in the image
    property p_latch(ev, int b);
        ev |-> ##2 canGlobalInterruptFlags[b];
    endproperty
    a_ovl_image: assert property (s_live |-> canGlobalStatus[6] == $past(ovlSending))
        else $error("overload bit wrong");
    a_tx_busy: assert property (s_live |-> canGlobalStatus[4]
        == ($past(txFrame) || ($past(inIfs) && $past(txPending))))
        else $error("tx busy bit wrong");
    a_rx_busy: assert property (s_live |-> canGlobalStatus[3] == $past(rxFrame))
        else $error("rx busy bit wrong");
    a_enable_lag: assert property ($rose(controllerRunEnable) && !canGlobalStatus[2]
        |-> s_wait ##1 canGlobalStatus[2]) else $error("enable lag wrong");
    a_fault_bits: assert property (s_live |-> canGlobalStatus[1:0]
        == {$past(faultState[1]), $past(faultState) == 2'h1}) else $error("fault bits wrong");
    a_any_image: assert property (anyIrqPending == canGlobalInterruptFlags[7])
        else $error("request image wrong");
    a_wrap_set: assert property (!$past(rst) && canTimer == 16'h0000
        && $past(canTimer) == 16'hffff |-> ##2 canGlobalInterruptFlags[5])
        else $error("wrap flag not set");
    a_wrap_clear: assert property (sfrWr && sfrAddr == 8'h9b && !sfrWdata[5]
        && canTimer != 16'h0000 |-> ##2 !canGlobalInterruptFlags[5])
        else $error("wrap not cleared");
    a_ovr_sticky: assert property ($fell(canGlobalInterruptFlags[4])
        |-> $past(sfrWr, 2) && $past(sfrAddr, 2) == 8'h9b && !$past(sfrWdata[4], 2))
        else $error("overrun lost");
    a_stuff_latch: assert property (p_latch(stuffErr, 3)) else $error("stuff flag lost");
    a_form_latch: assert property (p_latch(formErr, 1)) else $error("form flag lost");
endmodule
bind cangs_top cangs_monitor u_cangs_monitor (
    .clk                     (clk),
    .rst                     (rst),
    .sfrAddr                 (sfrAddr),
    .sfrWr                   (sfrWr),
    .sfrWdata                (sfrWdata),
    .controllerRunEnable     (controllerRunEnable),
    .ovlSending              (ovlSending),
    .txFrame                 (txFrame),
    .txPending               (txPending),
    .inIfs                   (inIfs),
    .rxFrame                 (rxFrame),
    .faultState              (faultState),
    .canTimer                (canTimer),
    .stuffErr                (stuffErr),
    .formErr                 (formErr),
    .canGlobalStatus         (canGlobalStatus),
    .canGlobalInterruptFlags (canGlobalInterruptFlags),
    .anyIrqPending           (anyIrqPending)
);
`default_nettype wire

/* File: test/cangs_bus_node.sv */
// Far side stand-in: bus error events and the free running CAN timer
`default_nettype none
module cangs_bus_node (
    input  wire logic        clk,
    input  wire logic [3:0]  evReq,     // One-hot error to raise
    input  wire logic [15:0] tmrSeed,   // Timer load value
    input  wire logic        tmrLoad,   // Load the timer
    output logic      [3:0]  evOut,     // Stuff, crc, form, ack pulses
    output logic      [15:0] canTimer   // Timer value
);
    timeunit 1ns;
    timeprecision 1ns;
    initial canTimer = 16'h0000;
    // counting timer and single-bit error pulses
    always @(posedge clk) begin
        evOut <= evReq;
        canTimer <= tmrLoad ? tmrSeed : canTimer + 16'h0001;
    end
endmodule
`default_nettype wire

/* File: test/can_global_status_and_irq_flags_bench.sv */
// Self-checking bench for the CAN global status block
`default_nettype none
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin badCount++; \
    $display("ERROR %0t got %h want %h", $time, got, exp); end end
module can_global_status_and_irq_flags_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, sfrWr = 0, sfrRd = 0, controllerRunEnable = 0, tmrLoad = 0;
    logic ovlSending = 0, txFrame = 0, txPending = 0, inIfs = 0, rxFrame = 0, otherIrq = 0;
    logic timerWrapIrqEnable = 0, bufferFull = 0, errIrqEnable = 0, bufIrqEnable = 0;
    logic stuffErr, crcErr, formErr, ackErr, anyIrqPending;
    logic [1:0]  faultState = 0;
    logic [3:0]  evReq = 0;
    logic [7:0]  sfrAddr = 0, sfrWdata = 0, sfrRdata, canGlobalStatus, canGlobalInterruptFlags, rd;
    logic [15:0] canTimer, tmrSeed = 0;
    logic [31:0] rnd;
    logic [7:0]  expF;
    int badCount = 0, totalChecks = 0, seed = 32'hfc55_79a6, i;
    cangs_top u_cangs_top (
        .clk                     (clk),
        .rst                     (rst),
        .sfrAddr                 (sfrAddr),
        .sfrWr                   (sfrWr),
        .sfrRd                   (sfrRd),
        .sfrWdata                (sfrWdata),
        .sfrRdata                (sfrRdata),
        .controllerRunEnable     (controllerRunEnable),
        .ovlSending              (ovlSending),
        .txFrame                 (txFrame),
        .txPending               (txPending),
        .inIfs                   (inIfs),
        .rxFrame                 (rxFrame),
        .faultState              (faultState),
        .canTimer                (canTimer),
        .timerWrapIrqEnable      (timerWrapIrqEnable),
        .bufferFull              (bufferFull),
        .stuffErr                (stuffErr),
        .crcErr                  (crcErr),
        .formErr                 (formErr),
        .ackErr                  (ackErr),
        .otherIrq                (otherIrq),
        .errIrqEnable            (errIrqEnable),
        .bufIrqEnable            (bufIrqEnable),
        .canGlobalStatus         (canGlobalStatus),
        .canGlobalInterruptFlags (canGlobalInterruptFlags),
        .anyIrqPending           (anyIrqPending)
    );
    cangs_bus_node u_cangs_bus_node (.clk(clk), .evReq(evReq), .tmrSeed(tmrSeed),
        .tmrLoad(tmrLoad), .evOut({stuffErr, crcErr, formErr, ackErr}), .canTimer(canTimer));
    always #25 clk = ~clk;
    // One register access, strobe held for one edge
    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {sfrWr, sfrRd, sfrAddr, sfrWdata} = {wr, !wr, a, d};
        @(negedge clk);
        {sfrWr, sfrRd} = 2'b00;
        rd = sfrRdata;
    endtask
    // Expected status image
    function automatic logic [7:0] expSta(input logic en);
        return {1'b0, ovlSending, 1'b0, txFrame | (txPending & inIfs), rxFrame, en,
            faultState[1], faultState == 2'h1};
    endfunction
    // Expected request for a flag image
    function automatic logic expAny(input logic [7:0] f);
        return (f[5] & timerWrapIrqEnable) | (f[4] & bufIrqEnable) | ((|f[3:0]) & errIrqEnable)
            | otherIrq;
    endfunction
    task automatic printVerdict;
        if (badCount == 0 && totalChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #250_000;
        badCount++;
        printVerdict();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        sfr(0, 8'h9b, 8'h00);
        `CHK(rd, 8'h00)
        sfr(0, 8'haa, 8'h00);
        `CHK(rd, 8'h00)
        // Random live status inputs
        for (i = 0; i < 30; i++) begin
            rnd = $random(seed);
            {ovlSending, txFrame, txPending, inIfs, rxFrame, faultState} = rnd[6:0];
            sfr(0, 8'haa, 8'h00);
            `CHK(rd, expSta(1'b0))
        end
        {ovlSending, txFrame, txPending, inIfs, rxFrame, faultState} = 7'h00;
        controllerRunEnable = 1;
        repeat (2) @(negedge clk);
        `CHK(canGlobalStatus[2], 1'b0)
        repeat (2) @(negedge clk);
        `CHK(canGlobalStatus[2], 1'b1)
        controllerRunEnable = 0;
        repeat (3) @(negedge clk);
        `CHK(canGlobalStatus[2], 1'b0)
        // Each bus error in turn, raised then cleared
        for (i = 0; i < 4; i++) begin
            rnd = $random(seed);
            errIrqEnable = rnd[0];
            expF = {4'h0, 4'h8 >> i};
            evReq = 4'h8 >> i;
            @(negedge clk);
            evReq = 4'h0;
            repeat (3) @(negedge clk);
            `CHK(canGlobalInterruptFlags, {expAny(expF), 3'h0, expF[3:0]})
            sfr(1, 8'h9b, 8'h3f ^ expF); // reserved bits written zero
            repeat (2) @(negedge clk);
            `CHK(canGlobalInterruptFlags, 8'h00)
        end
        {tmrSeed, tmrLoad} = {16'hfffc, 1'b1};
        @(negedge clk);
        tmrLoad = 0;
        repeat (8) @(negedge clk);
        `CHK(canGlobalInterruptFlags, 8'h20)
        timerWrapIrqEnable = 1;
        repeat (2) @(negedge clk);
        `CHK(anyIrqPending, 1'b1)
        sfr(1, 8'h9b, 8'h1f); // software clears wrap flag
        repeat (2) @(negedge clk);
        `CHK(canGlobalInterruptFlags, 8'h00)
        {bufIrqEnable, bufferFull} = 2'b11;
        @(negedge clk);
        bufferFull = 0;
        sfr(1, 8'h9b, 8'h10);
        sfr(1, 8'haa, 8'h00);
        sfr(0, 8'h9b, 8'h00);
        `CHK(rd, 8'h90)
        sfr(1, 8'h9b, 8'h00);
        repeat (2) @(negedge clk);
        `CHK(canGlobalInterruptFlags, 8'h00)
        sfr(0, 8'h55, 8'h00);
        `CHK(rd, 8'h00)
        otherIrq = 1;
        repeat (2) @(negedge clk);
        `CHK(anyIrqPending, 1'b1)
        printVerdict();
    end
endmodule
`default_nettype wire
